// ==== rtl/pbr_pkg.sv ====
// Purpose: Constants shared by the port bit access block.
// Assumes: 16-bit byte-addressed internal bus, 8-bit data.
// Notes: Addresses for the port registers are free choices held here.
package pbr_pkg;
    localparam logic [15:0] ADDR_DIR = 16'hffe8; // Direction select register.
    localparam logic [15:0] ADDR_LATCH = 16'hffd8; // Output latch register.
    localparam logic [15:0] ADDR_RELOAD = 16'hffb0; // Shared counter and load address.
    localparam logic [15:0] RAM_BASE = 16'hfb80; // Small on-chip work RAM.
    localparam int RAM_AW = 5;
    localparam logic [15:0] RAM_MASK = 16'hffe0;
    localparam logic [15:0] END_ADDR = 16'hffff; // Highest legal move address.
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] WO_READ = 8'hff; // Read value of a write-only register.
    localparam logic [7:0] EMPTY_READ = 8'h00; // Any value is allowed here.
    // Bit operation codes.
    localparam logic [2:0] OP_SET = 3'h0;
    localparam logic [2:0] OP_CLR = 3'h1;
    localparam logic [2:0] OP_NOT = 3'h2;
    localparam logic [2:0] OP_ST = 3'h3;
    localparam logic [2:0] OP_IST = 3'h4;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RD = 5'b00010,
        ST_WR = 5'b00100,
        ST_MRD = 5'b01000,
        ST_MWR = 5'b10000
    } pbr_state_t;
endpackage : pbr_pkg

// ==== rtl/pbr_ram.sv ====
// Purpose: Small work RAM with a registered read port.
// Assumes: One access per cycle.
// Notes: Contents are not reset.
`timescale 1ns/1ps
module pbr_ram (
    // Clock.
    input wire logic core_clk_i,
    // Access.
    input wire logic we_i,
    input wire logic [pbr_pkg::RAM_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:(1<<pbr_pkg::RAM_AW)-1];

    // Write and registered read share one address.
    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : pbr_ram

// ==== rtl/pbr_port.sv ====
// Purpose: Port registers and the byte access engine for bit and block-move operations.
// Assumes: Pins synchronous to core_clk_i; one command at a time, started when busy_o is low.
// Notes: Bit operations and block moves read whole bytes and write whole bytes back.
`timescale 1ns/1ps
// Behaviour
// R1 - Writes to unmapped addresses are dropped; reads there return an undefined value.
// R2 - Block move copies count-low bytes from source pointer to destination pointer.
// R3 - Software keeps destination end at or below ffff; pointer never wraps.
// R4 - Bit operations read the byte, change one bit, write the whole byte back.
// R5 - Shared address reads the live counter and writes the load register.
// R6 - Latch reads give pin level for inputs and latch value for outputs.
// R7 - Output pins are driven to the latch value.
// R8 - Software should keep a RAM shadow of the latch and write whole bytes.
// R9 - Direction register is write-only and reads as ff.
// R10 - Direction bit 0 means input, 1 means output.
// R11 - Input pins are not driven; their latch bits still store writes.
module pbr_port (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Plain byte access.
    input wire logic wr_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // Bit operation command.
    input wire logic bit_op_i,
    input wire logic [2:0] bit_code_i,
    input wire logic [2:0] bit_num_i,
    input wire logic carry_i,
    // Block move command.
    input wire logic move_i,
    input wire logic [15:0] source_pointer_i,
    input wire logic [15:0] destination_pointer_i,
    input wire logic [7:0] count_reg_low_i,
    // Status.
    output logic busy_o,
    // Port pins.
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    // Reload timer.
    output logic [7:0] reload_value_o,
    output logic [7:0] counter_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] dir_q;
    logic [7:0] latch_q;
    logic [7:0] reload_q;
    logic [7:0] cnt_q;
    pbr_pkg::pbr_state_t state_q;
    pbr_pkg::pbr_state_t state_d;
    logic [15:0] addr_q;
    logic [15:0] dst_q;
    logic [7:0] left_q;
    logic [2:0] code_q;
    logic [2:0] num_q;
    logic carry_q;
    logic [7:0] rdata_q;
    logic [7:0] ram_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Access steering: the engine owns the bus while busy.
    wire idle = (state_q == pbr_pkg::ST_IDLE);
    wire [15:0] acc_addr = idle ? addr_i : (state_q == pbr_pkg::ST_MWR ? dst_q : addr_q);
    wire do_rd = (state_q == pbr_pkg::ST_RD) || (state_q == pbr_pkg::ST_MRD);
    wire do_wr = (idle && wr_i && !bit_op_i && !move_i) || (state_q == pbr_pkg::ST_WR)
                 || (state_q == pbr_pkg::ST_MWR);
    wire hit_dir = (acc_addr == pbr_pkg::ADDR_DIR);
    wire hit_latch = (acc_addr == pbr_pkg::ADDR_LATCH);
    wire hit_reload = (acc_addr == pbr_pkg::ADDR_RELOAD);
    wire hit_ram = ((acc_addr & pbr_pkg::RAM_MASK) == pbr_pkg::RAM_BASE);
    wire [7:0] port_read = (pin_i & ~dir_q) | (latch_q & dir_q); // [R6] [R10]

    // Read mux: unmapped areas give a fixed filler value. [R1]
    wire [7:0] reg_read = hit_dir ? pbr_pkg::WO_READ : // [R9]
                          hit_latch ? port_read :
                          hit_reload ? cnt_q : // [R5]
                          pbr_pkg::EMPTY_READ;
    // The modify step must see the byte that the read step fetched. That byte comes
    // from a register or from the RAM, so the modify step takes the same selected byte
    // that the data output shows; a RAM target would otherwise be rewritten as filler.
    wire [7:0] read_byte = rdata_o;

    // Bit modify on the byte just read; other bits pass through unchanged. [R4]
    wire [7:0] bit_mask = 8'h01 << num_q;
    logic [7:0] modified;
    always_comb begin
        case (code_q)
            pbr_pkg::OP_SET: modified = read_byte | bit_mask;
            pbr_pkg::OP_CLR: modified = read_byte & ~bit_mask;
            pbr_pkg::OP_NOT: modified = read_byte ^ bit_mask;
            pbr_pkg::OP_ST: modified = carry_q ? (read_byte | bit_mask) : (read_byte & ~bit_mask);
            pbr_pkg::OP_IST: modified = carry_q ? (read_byte & ~bit_mask) : (read_byte | bit_mask);
            default: modified = read_byte;
        endcase
    end
    wire [7:0] wr_byte = idle ? wdata_i : modified;
    wire ram_sel_rd = hit_ram && (idle || do_rd);

    ////////////////////////////////////////////////////////////////////////////
    // RAM read data arrives one cycle later; the mux picks it by a tracked flag.
    logic ram_rd_q;
    pbr_ram u_ram (
        .core_clk_i(core_clk_i),
        .we_i(do_wr && hit_ram),
        .addr_i(acc_addr[pbr_pkg::RAM_AW-1:0]),
        .wdata_i(wr_byte),
        .rdata_o(ram_rdata)
    );

    // Last byte of a block move: the count is spent once this byte has been written.
    wire move_last = (left_q == 8'h01);

    // Next state of the access engine.
    always_comb begin
        case (state_q)
            pbr_pkg::ST_IDLE: begin
                if (bit_op_i) begin
                    state_d = pbr_pkg::ST_RD;
                end else if (move_i && count_reg_low_i != 8'h00) begin
                    state_d = pbr_pkg::ST_MRD; // [R2]
                end else begin
                    state_d = pbr_pkg::ST_IDLE;
                end
            end
            pbr_pkg::ST_RD: state_d = pbr_pkg::ST_WR;
            pbr_pkg::ST_WR: state_d = pbr_pkg::ST_IDLE;
            pbr_pkg::ST_MRD: state_d = pbr_pkg::ST_MWR;
            pbr_pkg::ST_MWR: state_d = move_last ? pbr_pkg::ST_IDLE : pbr_pkg::ST_MRD;
            default: state_d = pbr_pkg::ST_IDLE;
        endcase
    end

    // Engine state and operands.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= pbr_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bit operations keep one address; block moves step both pointers.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_q <= 16'h0000;
            dst_q <= 16'h0000;
            left_q <= 8'h00;
            code_q <= 3'h0;
            num_q <= 3'h0;
            carry_q <= 1'b0;
        end else if (idle) begin
            addr_q <= bit_op_i ? addr_i : source_pointer_i; // [R2]
            dst_q <= destination_pointer_i;
            left_q <= count_reg_low_i;
            code_q <= bit_op_i ? bit_code_i : 3'h7; // Move copies the byte unchanged.
            num_q <= bit_num_i;
            carry_q <= carry_i;
        end else if (state_q == pbr_pkg::ST_MWR) begin
            // The pointer is not guarded against wrap; software keeps it below the top. [R3]
            addr_q <= addr_q + 16'h0001;
            dst_q <= dst_q + 16'h0001;
            left_q <= left_q - 8'h01;
        end
    end

    // Read data register: register reads and RAM data both appear one cycle after the address.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ram_rd_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ram_rd_q <= ram_sel_rd;
            rdata_q <= reg_read;
        end
    end
    // Registered-read byte used by modify and by the data output.
    assign rdata_o = ram_rd_q ? ram_rdata : rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Port registers; a write to no register is simply dropped. [R1]
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dir_q <= pbr_pkg::DIR_RESET;
            latch_q <= pbr_pkg::LATCH_RESET;
            reload_q <= pbr_pkg::RELOAD_RESET;
        end else if (do_wr) begin
            if (hit_dir) begin
                dir_q <= wr_byte;
            end
            if (hit_latch) begin
                latch_q <= wr_byte; // Stored even for input bits. [R11]
            end
            if (hit_reload) begin
                reload_q <= wr_byte; // Writes go to the load register only. [R5]
            end
        end
    end

    // Reload counter counts down and reloads on reaching zero. Reads of the shared
    // address see this live count, not the load register, so a bit operation there
    // copies whatever count bits it read into the load register. [R5]
    wire cnt_zero = (cnt_q == 8'h00);
    wire [7:0] cnt_d = cnt_zero ? reload_q : cnt_q - 8'h01;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= pbr_pkg::RELOAD_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Pin drive: outputs follow the latch, inputs float. The latch is masked here rather
    // than at write time, so bits written while a pin is an input appear once the pin
    // turns to output.
    assign pin_o = latch_q & dir_q; // [R7]
    assign pin_oe_o = dir_q; // [R10] [R11]
    assign busy_o = !idle;
    assign reload_value_o = reload_q;
    assign counter_o = cnt_q;
endmodule : pbr_port

// ==== bench/pbr_port_monitor.sv ====
// Purpose: Assertions on the ports of the bit access block.
// Assumes: Only top-level ports are visible.
// Notes: Reads are judged only in idle cycles.
`timescale 1ns/1ps
module pbr_port_monitor (
    // Clock and reset.
    input logic core_clk_i,
    input logic resetn_i,
    // Requests.
    input logic wr_i,
    input logic [15:0] addr_i,
    input logic [7:0] wdata_i,
    input logic bit_op_i,
    input logic [2:0] bit_code_i,
    input logic [2:0] bit_num_i,
    input logic move_i,
    input logic [7:0] count_reg_low_i,
    input logic [7:0] pin_i,
    // Answers.
    input logic [7:0] rdata_o,
    input logic busy_o,
    input logic [7:0] pin_o,
    input logic [7:0] pin_oe_o,
    input logic [7:0] reload_value_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Which request is taken; a busy engine takes none, so those cycles are left out.
    wire idle = !busy_o && !wr_i && !bit_op_i && !move_i;
    wire wr_ok = !busy_o && wr_i && !bit_op_i && !move_i;
    wire op_ok = !busy_o && bit_op_i;
    wire mapped = addr_i inside {pbr_pkg::ADDR_DIR, pbr_pkg::ADDR_LATCH, pbr_pkg::ADDR_RELOAD}
        || (addr_i & pbr_pkg::RAM_MASK) == pbr_pkg::RAM_BASE;
    dir_read_a: assert property (idle && addr_i == pbr_pkg::ADDR_DIR |=> rdata_o == 8'hff)
        else $error("dir read");
    latch_read_a: assert property (idle && addr_i == pbr_pkg::ADDR_LATCH |=>
        rdata_o == (($past(pin_i) & ~$past(pin_oe_o)) | $past(pin_o))) else $error("latch read");
    drop_write_a: assert property (wr_ok && !mapped |=>
        $stable(pin_oe_o) && $stable(pin_o) && $stable(reload_value_o)) else $error("dropped");
    dir_write_a: assert property (wr_ok && addr_i == pbr_pkg::ADDR_DIR |=>
        pin_oe_o == $past(wdata_i)) else $error("dir write");
    load_write_a: assert property (wr_ok && addr_i == pbr_pkg::ADDR_RELOAD |=>
        reload_value_o == $past(wdata_i)) else $error("load write");
    no_drive_a: assert property ((pin_o & ~pin_oe_o) == 8'h00) else $error("input driven");
    op_busy_a: assert property (op_ok |=> busy_o [*2] ##1 !busy_o) else $error("op length");
    bit_set_a: assert property (op_ok && bit_code_i == pbr_pkg::OP_SET &&
        addr_i == pbr_pkg::ADDR_LATCH |-> ##3
        pin_o == (($past(pin_o, 3) | (8'h01 << $past(bit_num_i, 3))) & pin_oe_o))
        else $error("bit set");
    move_len_a: assert property (!busy_o && !bit_op_i && move_i && count_reg_low_i == 8'h01
        |=> busy_o [*2] ##1 !busy_o) else $error("move length");
    // Main traffic worth seeing at least once.
    cover property (op_ok && addr_i == pbr_pkg::ADDR_DIR);
    cover property (!busy_o && !bit_op_i && move_i && count_reg_low_i > 8'h01);
    cover property (wr_ok && !mapped);
endmodule : pbr_port_monitor
////////////////////////////////////////////////////////////////////////////////
bind pbr_port pbr_port_monitor u_mon (.*);

// ==== bench/pbr_pin_model.sv ====
// Purpose: Board side of the port pins.
// Assumes: Undriven pins take the level the bench sets.
// Notes: A wire shows the port's level only while the port drives it.
`timescale 1ns/1ps
module pbr_pin_model (
    // Port side.
    input logic [7:0] pin_o,
    input logic [7:0] pin_oe_o,
    // Board side.
    input logic [7:0] ext_i,
    output logic [7:0] pin_i
);
    // Mixing both parties keeps a stale port level off released wires.
    assign pin_i = (pin_o & pin_oe_o) | (ext_i & ~pin_oe_o);
endmodule : pbr_pin_model

// ==== bench/test_port_bit_rmw_access.sv ====
// Purpose: Self-checking bench for the port bit access block.
// Assumes: Commands start only while the engine is idle.
// Notes: Random bytes come from a shift register seeded with 83.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module test_port_bit_rmw_access;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wr_i = 1'b0, bit_op_i = 1'b0, move_i = 1'b0, carry_i = 1'b0;
    logic [15:0] addr_i = 16'h0000, src = 16'h0000, dst = 16'h0000;
    logic [7:0] wdata_i = 8'h00, cnt = 8'h00, ext = 8'h00, rnd = 8'h53, d, e, l, rd;
    logic [2:0] code = 3'h0, num = 3'h0;
    logic [7:0] rdata_o, pin_i, pin_o, pin_oe_o, reload_value_o, counter_o, mem [4];
    logic busy_o;
    int error_cnt = 0, num_checks = 0, cycles = 0;
    pbr_port dut (.core_clk_i, .resetn_i, .wr_i, .addr_i, .wdata_i, .rdata_o, .bit_op_i,
        .bit_code_i(code), .bit_num_i(num), .carry_i, .move_i, .source_pointer_i(src),
        .destination_pointer_i(dst), .count_reg_low_i(cnt), .busy_o, .pin_i, .pin_o,
        .pin_oe_o, .reload_value_o, .counter_o);
    pbr_pin_model u_pins (.pin_o, .pin_oe_o, .ext_i(ext), .pin_i);
    // Free-running clock.
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    // Shift register step for repeatable random bytes.
    function automatic logic [7:0] nxt();
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        return rnd;
    endfunction : nxt
    // Byte after one bit operation; only the chosen bit may differ.
    function automatic logic [7:0] bit_fn(input logic [2:0] c, input logic [7:0] b,
        input logic [2:0] n, input logic v);
        case (c)
            3'h0: b[n] = 1'b1;
            3'h1: b[n] = 1'b0;
            3'h2: b[n] = ~b[n];
            3'h3: b[n] = v;
            default: b[n] = ~v;
        endcase
        return b;
    endfunction : bit_fn
    task automatic put_byte(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : put_byte
    task automatic get_byte(input logic [15:0] a);
        @(posedge core_clk_i);
        addr_i <= a;
        @(posedge core_clk_i);
        #1 rd = rdata_o;
    endtask : get_byte
    task automatic bit_op(input logic [15:0] a, input logic [2:0] c, input logic [2:0] n);
        @(posedge core_clk_i);
        bit_op_i <= 1'b1;
        addr_i <= a;
        code <= c;
        num <= n;
        carry_i <= rnd[0];
        @(posedge core_clk_i);
        bit_op_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask : bit_op
    task automatic move(input logic [15:0] s, input logic [15:0] t, input logic [7:0] n);
        @(posedge core_clk_i);
        move_i <= 1'b1;
        src <= s;
        dst <= t;
        cnt <= n;
        @(posedge core_clk_i);
        move_i <= 1'b0;
        repeat (2 * n + 1) @(posedge core_clk_i);
    endtask : move
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // A hang counts as a mismatch; the run needs well under this many cycles.
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Main sequence.
    initial begin
        repeat (16) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        ext <= 8'h5a;
        get_byte(pbr_pkg::ADDR_DIR);
        `CHK("dir read", 8'hff, rd)
        get_byte(pbr_pkg::ADDR_LATCH);
        `CHK("input read", 8'h5a, rd)
        for (int i = 0; i < 8; i++) begin
            d = nxt();
            l = nxt();
            e = nxt();
            ext <= e;
            put_byte(pbr_pkg::ADDR_DIR, d);
            put_byte(pbr_pkg::ADDR_LATCH, l);
            get_byte(pbr_pkg::ADDR_LATCH);
            `CHK("pin enables", d, pin_oe_o)
            `CHK("pin outputs", l & d, pin_o)
            `CHK("latch read", (e & ~d) | (l & d), rd)
        end
        put_byte(pbr_pkg::ADDR_DIR, 8'hff);
        for (int c = 0; c < 5; c++) begin
            l = nxt();
            put_byte(pbr_pkg::ADDR_LATCH, l);
            bit_op(pbr_pkg::ADDR_LATCH, c[2:0], l[2:0]);
            `CHK("bit op", bit_fn(c[2:0], l, l[2:0], carry_i), pin_o)
        end
        put_byte(pbr_pkg::ADDR_DIR, 8'h3f);
        put_byte(pbr_pkg::ADDR_LATCH, 8'h80);
        ext <= 8'h40;
        bit_op(pbr_pkg::ADDR_LATCH, pbr_pkg::OP_SET, 3'h0);
        put_byte(pbr_pkg::ADDR_DIR, 8'hff);
        `CHK("set on mixed port", 8'h41, pin_o)
        put_byte(pbr_pkg::ADDR_DIR, 8'h3f);
        bit_op(pbr_pkg::ADDR_DIR, pbr_pkg::OP_CLR, 3'h0);
        `CHK("clear on dir", 8'hfe, pin_oe_o)
        put_byte(16'h0100, 8'h5a);
        get_byte(16'h0100);
        `CHK("unmapped read", pbr_pkg::EMPTY_READ, rd)
        `CHK("dir kept", 8'hfe, pin_oe_o)
        for (int i = 0; i < 4; i++) begin
            mem[i] = nxt();
            put_byte(pbr_pkg::RAM_BASE + 16'(i), mem[i]);
        end
        move(pbr_pkg::RAM_BASE, pbr_pkg::RAM_BASE + 16'h0010, 8'h04);
        for (int i = 0; i < 4; i++) begin
            get_byte(pbr_pkg::RAM_BASE + 16'h0010 + 16'(i));
            `CHK("moved byte", mem[i], rd)
        end
        put_byte(pbr_pkg::ADDR_DIR, 8'hff);
        put_byte(pbr_pkg::RAM_BASE, 8'h80);
        bit_op(pbr_pkg::RAM_BASE, pbr_pkg::OP_SET, 3'h0);
        move(pbr_pkg::RAM_BASE, pbr_pkg::ADDR_LATCH, 8'h01);
        `CHK("shadow to latch", 8'h81, pin_o)
        d = nxt();
        put_byte(pbr_pkg::ADDR_RELOAD, d | 8'h80);
        `CHK("load write", d | 8'h80, reload_value_o)
        bit_op(pbr_pkg::ADDR_RELOAD, pbr_pkg::OP_CLR, 3'h7);
        `CHK("load bit clear", 1'b0, reload_value_o[7])
        #1;
        `CHK("load from counter", ((d | 8'h80) - 8'h01) & 8'h7f, reload_value_o)
        `CHK("counter runs", (d | 8'h80) - 8'h04, counter_o)
        print_verdict();
    end
endmodule : test_port_bit_rmw_access
